// *** logic/rtcsa_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtcsa_fifo
  import rtcsa_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int D = FIFO_D
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  rtcsa_fifo_if.fifo f
);
  localparam int AW = $clog2(D);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [W-1:0] mem_ff [D];
  logic [W-1:0] nxt_mem [D];
  logic [AW:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic full, empty;

  // extra pointer bit tells full from empty
  assign full = (wp_ff[AW] != rp_ff[AW]) &&
                (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  assign empty = (wp_ff == rp_ff);
  assign f.in_ready = !full;
  assign f.out_valid = !empty;
  assign f.out_data = mem_ff[rp_ff[AW-1:0]];

  always_comb begin
    nxt_mem = mem_ff;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    if (f.in_valid && !full) begin
      nxt_mem[wp_ff[AW-1:0]] = f.in_data;
      nxt_wp = wp_ff + 1'b1;
    end
    if (!empty && f.out_ready) begin
      nxt_rp = rp_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else if (ce) begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      mem_ff <= nxt_mem;
    end
  end

endmodule
`default_nettype wire

// *** logic/rtcsa_fifo_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface rtcsa_fifo_if #(parameter int W = 12);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fifo(input in_valid, in_data, out_ready,
               output in_ready, out_valid, out_data);
  modport prod(output in_valid, in_data, out_ready,
               input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// *** logic/rtcsa_pkg.sv ***
package rtcsa_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int TMO_MIN_MS = 500;
  localparam int TMO_MAX_MS = 1000;
  // least time, rounded up to whole cycles
  localparam int TMO_CYC_DEF = (TMO_MIN_MS * 1000000 + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // bus fields and values
  // ----------------------------------------------------------------
  localparam logic [6:0] SLV_ADDR = 7'h32;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] PTR_RST = 4'hF;
  localparam logic [3:0] FMT_WR = 4'h0;
  localparam logic [3:0] FMT_RDNOW = 4'h4;
  localparam int PTR_LSB = 4;
  localparam int FMT_LSB = 0;
  localparam logic SYNC_RST = 1'b1;
  localparam logic [31:0] TMR_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // write-data buffer
  // ----------------------------------------------------------------
  localparam int FIFO_W = 12;
  localparam int FIFO_D = 16;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_PTR = 3'h2,
    ST_WR = 3'h3,
    ST_RD = 3'h4,
    ST_WAIT = 3'h5
  } rtcsa_st_t;

endpackage

// *** logic/rtcsa_slave.sv ***
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - sda fall with scl high opens access
// - sda rise with scl high ends access
// - data changes only while scl low (a timeout release can come while scl high)
// - eight-bit bytes, each acknowledged by receiver
// - ack driven after eighth fall, released ninth
// - master nack: slave keeps line released
// - first byte: address msb first, then direction
// - answer only to address 0110010
// - repeated start resends address, may turn direction
// - second write byte: pointer and format
// - writes go to pointer, increment, wrap F-0
// - read method one via repeated start
// - every stop sets pointer to F
// - format 4 starts reading right away
// - plain read starts from default pointer F
// - carries held from start until access end
// - access open past timeout is force-closed
// - timeout counts from first start only
// - after timeout: no ack, reads give FFh
module rtcsa_slave
  import rtcsa_pkg::*;
#(
  parameter int unsigned TMO_CYC = TMO_CYC_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic carry_hold,
  output logic tmo_lock,
  output logic [3:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [3:0] wr_addr,
  output logic [7:0] wr_data
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge finding
  // ----------------------------------------------------------------
  logic scl_m_ff, scl_s_ff, scl_d_ff, sda_m_ff, sda_s_ff, sda_d_ff;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_m_ff <= SYNC_RST;
      scl_s_ff <= SYNC_RST;
      scl_d_ff <= SYNC_RST;
      sda_m_ff <= SYNC_RST;
      sda_s_ff <= SYNC_RST;
      sda_d_ff <= SYNC_RST;
    end else if (ce) begin
      scl_m_ff <= scl_i;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= sda_i;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
    end
  end

  assign scl_rise = scl_s_ff && !scl_d_ff;
  assign scl_fall = !scl_s_ff && scl_d_ff;
  // line changes while scl stays high are conditions, not data
  assign start_det = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff;
  assign stop_det = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff;

  // ----------------------------------------------------------------
  // write buffer
  // ----------------------------------------------------------------
  rtcsa_fifo_if #(.W(FIFO_W)) wq ();

  rtcsa_fifo #(.W(FIFO_W), .D(FIFO_D)) u_wq (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .f(wq.fifo)
  );

  assign wq.out_ready = wr_ready;
  assign wr_valid = wq.out_valid;
  assign wr_addr = wq.out_data[11:8];
  assign wr_data = wq.out_data[7:0];

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  rtcsa_st_t st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt, ptr_ff, nxt_ptr;
  logic [7:0] sh_ff, nxt_sh;
  logic [31:0] tmr_ff, nxt_tmr;
  logic ack_ph_ff, nxt_ack_ph, oe_ff, nxt_oe, mack_ff, nxt_mack;
  logic acc_ff, nxt_acc, lock_ff, nxt_lock;
  logic ok, do_load, tmo_hit;

  assign tmo_hit = acc_ff && (tmr_ff >= 32'(TMO_CYC - 1));

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_ptr = ptr_ff;
    nxt_sh = sh_ff;
    nxt_tmr = tmr_ff;
    nxt_ack_ph = ack_ph_ff;
    nxt_oe = oe_ff;
    nxt_mack = mack_ff;
    nxt_acc = acc_ff;
    nxt_lock = lock_ff;
    ok = 1'b0;
    do_load = 1'b0;
    wq.in_valid = 1'b0;
    wq.in_data = {ptr_ff, sh_ff};
    if (acc_ff) begin
      nxt_tmr = tmr_ff + 32'h0000_0001;
    end
    if (start_det) begin
      nxt_st = ST_ADDR;
      nxt_cnt = '0;
      nxt_ack_ph = 1'b0;
      nxt_oe = 1'b0;
      // repeated start leaves the timer running
      if (!acc_ff) begin
        nxt_acc = 1'b1;
        nxt_tmr = TMR_RST;
        nxt_lock = 1'b0;
      end
    end else if (stop_det || tmo_hit) begin
      nxt_st = ST_IDLE;
      nxt_acc = 1'b0;
      nxt_ptr = PTR_RST;
      nxt_oe = 1'b0;
      nxt_lock = tmo_hit ? 1'b1 : lock_ff;
    end else begin
      unique case (st_ff)
        // released line: no ack, reads see FFh
        ST_IDLE, ST_WAIT: begin
        end
        ST_ADDR, ST_PTR, ST_WR: begin
          if (scl_rise && !ack_ph_ff) begin
            nxt_sh = {sh_ff[6:0], sda_s_ff};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && !ack_ph_ff && cnt_ff == BYTE_BITS) begin
            // no stretching, so a full buffer can only refuse
            unique case (st_ff)
              ST_ADDR: ok = (sh_ff[7:1] == SLV_ADDR);
              ST_PTR: ok = 1'b1;
              default: ok = wq.in_ready;
            endcase
            nxt_ack_ph = 1'b1;
            nxt_cnt = '0;
            nxt_oe = ok;
            if (st_ff == ST_PTR) begin
              nxt_ptr = sh_ff[7:PTR_LSB];
            end
            if (st_ff == ST_WR && ok) begin
              wq.in_valid = 1'b1;
              nxt_ptr = ptr_ff + 4'h1;
            end
          end else if (scl_fall && ack_ph_ff) begin
            nxt_ack_ph = 1'b0;
            nxt_oe = 1'b0;
            if (!oe_ff) begin
              nxt_st = ST_WAIT;
            end else if (st_ff == ST_ADDR) begin
              // read bit set: start at pointer, F after a stop
              if (sh_ff[0]) begin
                do_load = 1'b1;
              end else begin
                nxt_st = ST_PTR;
              end
            end else if (st_ff == ST_PTR) begin
              if (sh_ff[3:FMT_LSB] == FMT_RDNOW) begin
                do_load = 1'b1;
              end else begin
                nxt_st = ST_WR;
              end
            end
          end
        end
        ST_RD: begin
          if (scl_fall && !ack_ph_ff) begin
            if (cnt_ff == BYTE_BITS - 4'h1) begin
              nxt_oe = 1'b0;
              nxt_ack_ph = 1'b1;
              nxt_cnt = '0;
            end else begin
              nxt_cnt = cnt_ff + 4'h1;
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_oe = !sh_ff[6];
            end
          end else if (scl_rise && ack_ph_ff) begin
            nxt_mack = !sda_s_ff;
          end else if (scl_fall && ack_ph_ff) begin
            nxt_ack_ph = 1'b0;
            if (mack_ff) begin
              do_load = 1'b1;
            end else begin
              nxt_st = ST_WAIT;
            end
          end
        end
        default: begin
          nxt_st = ST_IDLE;
          nxt_oe = 1'b0;
        end
      endcase
      if (do_load) begin
        nxt_st = ST_RD;
        nxt_sh = rd_data;
        nxt_oe = !rd_data[7];
        nxt_cnt = '0;
        nxt_ptr = ptr_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
      ptr_ff <= PTR_RST;
      sh_ff <= '0;
      tmr_ff <= TMR_RST;
      ack_ph_ff <= 1'b0;
      oe_ff <= 1'b0;
      mack_ff <= 1'b0;
      acc_ff <= 1'b0;
      lock_ff <= 1'b0;
      sda_o <= 1'b0;
    end else if (ce) begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      ptr_ff <= nxt_ptr;
      sh_ff <= nxt_sh;
      tmr_ff <= nxt_tmr;
      ack_ph_ff <= nxt_ack_ph;
      oe_ff <= nxt_oe;
      mack_ff <= nxt_mack;
      acc_ff <= nxt_acc;
      lock_ff <= nxt_lock;
      sda_o <= 1'b0;
    end
  end

  // open drain: only ever pulls low, never makes a start; a timeout release while scl is high makes a stop
  assign sda_oe = oe_ff;
  assign carry_hold = acc_ff;
  assign tmo_lock = lock_ff;
  assign rd_addr = ptr_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_first_start;
    ce && start_det && !acc_ff;
  endsequence

  sequence s_close;
    ce && (stop_det || tmo_hit) && !start_det;
  endsequence

  access_open_a: assert property (
    s_first_start |=> acc_ff && st_ff == ST_ADDR && tmr_ff == TMR_RST)
    else $error("start did not open access");

  stop_ptr_a: assert property (
    s_close |=> ptr_ff == PTR_RST && !acc_ff && !sda_oe)
    else $error("close did not reset pointer");

  oe_edge_a: assert property (
    ce && !scl_fall && !start_det && !stop_det && !tmo_hit && !do_load
    |=> $stable(sda_oe))
    else $error("sda drive changed outside scl low");

  addr_ack_a: assert property (
    ce && st_ff == ST_ADDR && scl_fall && !ack_ph_ff && cnt_ff == BYTE_BITS
    && !start_det && !stop_det && !tmo_hit
    |=> sda_oe == ($past(sh_ff[7:1]) == SLV_ADDR))
    else $error("address ack wrong");

  idle_release_a: assert property (
    (st_ff == ST_IDLE || st_ff == ST_WAIT) |-> !sda_oe)
    else $error("bus driven while not addressed");

  tmo_close_a: assert property (
    ce && tmo_hit && !start_det |=> tmo_lock && !carry_hold)
    else $error("timeout did not close access");

  rstart_tmr_a: assert property (
    ce && start_det && acc_ff |=> tmr_ff == $past(tmr_ff) + 32'h1)
    else $error("repeated start restarted timer");

  write_wrap_a: assert property (
    ce && wq.in_valid && ptr_ff == PTR_RST |=> ptr_ff == 4'h0)
    else $error("pointer did not wrap");

  fmt_read_a: assert property (
    ce && st_ff == ST_PTR && ack_ph_ff && scl_fall && oe_ff
    && sh_ff[3:0] == FMT_RDNOW && !start_det && !stop_det && !tmo_hit
    |=> st_ff == ST_RD ##1 !ack_ph_ff)
    else $error("format 4 did not start read");

  nack_release_a: assert property (
    ce && st_ff == ST_RD && ack_ph_ff && scl_fall && !mack_ff
    && !start_det && !stop_det && !tmo_hit
    |=> st_ff == ST_WAIT && !sda_oe)
    else $error("line held after master nack");

endmodule
`default_nettype wire

// *** test/rtc_i2c_slave_access_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) chk_v(32'(a), 32'(e));
module rtc_i2c_slave_access_tb
  import rtcsa_pkg::*;
;
  localparam int TMO = 12000;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic wr_ready = 1'b0;
  logic scl, m_oe, sda_o, sda_oe, carry_hold, tmo_lock, wr_valid;
  logic [3:0] rd_addr, wr_addr;
  logic [7:0] rd_data, wr_data;
  logic [8:0] q;
  wire logic sda;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  // ------------------------------------------------
  // harness
  // ------------------------------------------------
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  assign sda = !(sda_oe | m_oe);
  // register file stand-in, distinct value per address
  function automatic logic [7:0] rv(input logic [3:0] a);
    return {a ^ 4'h5, a};
  endfunction
  assign rd_data = rv(rd_addr);

  rtcsa_slave #(.TMO_CYC(TMO)) dut (.clk(clk), .sys_rst(sys_rst),
    .ce(ce), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .carry_hold(carry_hold), .tmo_lock(tmo_lock),
    .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data));
  rtcsa_mstr #(.GAP_CYC(2000)) u_m (.clk(clk), .scl(scl),
    .m_oe(m_oe), .sda(sda));

  task automatic chk_v(input logic [31:0] a, input logic [31:0] e);
    num_checks++;
    if (a !== e) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
      error_cnt++;
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wb(input logic [7:0] d, input logic ack);
    u_m.xb({d, 1'b1}, q);
    `CHK(q[0], !ack)
  endtask

  task automatic rb(input logic [3:0] a, input logic last);
    u_m.xb({8'hFF, last}, q);
    `CHK(q[8:1], rv(a))
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  // fill the buffer past full with the user stalled, then drain
  task automatic t_write();
    u_m.start();
    `CHK(carry_hold, 1'b1)
    wb({SLV_ADDR, 1'b0}, 1'b1);
    wb({4'hE, FMT_WR}, 1'b1);
    for (int i = 0; i < 16; i++) begin
      wb(8'(8'h30 + i), 1'b1);
    end
    wb(8'h77, 1'b0);
    u_m.stop();
    `CHK(carry_hold, 1'b0)
    `CHK(rd_addr, PTR_RST)
    // enable low: a ready pulse must not pop an entry
    @(posedge clk) ce <= 1'b0;
    wr_ready <= 1'b1;
    repeat (4) @(posedge clk);
    wr_ready <= 1'b0;
    ce <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      `CHK(wr_valid, 1'b1)
      `CHK(wr_addr, 4'(4'hE + i))
      `CHK(wr_data, 8'(8'h30 + i))
      @(posedge clk) wr_ready <= 1'b1;
      @(posedge clk) wr_ready <= 1'b0;
    end
    @(negedge clk);
    `CHK(wr_valid, 1'b0)
  endtask

  task automatic t_rd1();
    u_m.start();
    wb({SLV_ADDR, 1'b0}, 1'b1);
    wb({4'hE, FMT_WR}, 1'b1);
    u_m.start();
    wb({SLV_ADDR, 1'b1}, 1'b1);
    rb(4'hE, 1'b0);
    rb(4'hF, 1'b0);
    rb(4'h0, 1'b1);
    u_m.stop();
  endtask

  task automatic t_rd2();
    u_m.start();
    wb({SLV_ADDR, 1'b0}, 1'b1);
    wb({4'h2, FMT_RDNOW}, 1'b1);
    rb(4'h2, 1'b0);
    rb(4'h3, 1'b1);
    u_m.stop();
  endtask

  task automatic t_rd3();
    u_m.start();
    wb({SLV_ADDR, 1'b1}, 1'b1);
    rb(4'hF, 1'b0);
    rb(4'h0, 1'b1);
    repeat (10) @(posedge clk);
    `CHK(sda_oe, 1'b0)
    `CHK(sda_o, 1'b0)
    u_m.stop();
  endtask

  task automatic t_badaddr();
    u_m.start();
    wb({7'h33, 1'b0}, 1'b0);
    u_m.start();
    wb({7'h12, 1'b1}, 1'b0);
    u_m.stop();
  endtask

  // master stalls mid-access; repeated start must not rearm
  task automatic t_tmo();
    int t0;
    int n;
    t0 = cyc;
    u_m.start();
    wb({SLV_ADDR, 1'b0}, 1'b1);
    repeat (3000) @(posedge clk);
    u_m.start();
    wb({SLV_ADDR, 1'b0}, 1'b1);
    n = 0;
    while (carry_hold !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) begin
      error_cnt++;
      wrap_up();
    end
    `CHK(cyc - t0 >= TMO && cyc - t0 < TMO + 100, 1'b1)
    `CHK(tmo_lock, 1'b1)
    `CHK(rd_addr, PTR_RST)
    wb(8'h55, 1'b0);
    u_m.xb(9'h1FF, q);
    `CHK(q[8:1], 8'hFF)
    u_m.stop();
    u_m.start();
    `CHK(tmo_lock, 1'b0)
    wb({SLV_ADDR, 1'b0}, 1'b1);
    u_m.stop();
  endtask

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(rd_addr, PTR_RST)
    `CHK(carry_hold, 1'b0)
    t_write();
    t_rd1();
    t_rd2();
    t_rd3();
    t_badaddr();
    t_tmo();
    wrap_up();
  end
endmodule
`undef CHK
`default_nettype wire

// *** test/rtcsa_mstr.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// two-wire bus master model
// ------------------------------------------------
// scl rests high between frames; sda released means pulled up
module rtcsa_mstr #(
  parameter int GAP_CYC = 15250
) (
  input wire logic clk,
  output var logic scl,
  output var logic m_oe,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  // start and repeated start alike
  task automatic start();
    m_oe <= 1'b0;
    w(10);
    scl <= 1'b1;
    w(20);
    m_oe <= 1'b1;
    w(20);
    scl <= 1'b0;
    w(10);
  endtask

  // quiet gap after stop before any new start
  task automatic stop();
    m_oe <= 1'b1;
    w(10);
    scl <= 1'b1;
    w(20);
    m_oe <= 1'b0;
    w(GAP_CYC);
  endtask

  // eight bits msb first then the ninth (ack) bit
  task automatic xb(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      m_oe <= !d[i];
      w(10);
      scl <= 1'b1;
      w(20);
      q[i] = sda;
      scl <= 1'b0;
      w(10);
    end
  endtask
endmodule
`default_nettype wire
